// [design/ivs_top.sv]
// Vector offset table, priority shadow select and serviced-IRQ status
`timescale 1ns/1ps
`include "ivs_params.svh"
module ivs_top
    import ivs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [`IVS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [31:0] exception_base,
    input wire ivs_accept_t accept_in,
    output ivs_vector_t vector_out_reg
);
    localparam int NSRC = `IVS_NUM_SRC;
    localparam int OFW = `IVS_OFF_MSB - `IVS_OFF_LSB + 1;

    logic [OFW-1:0] vector_offset_field [NSRC];
    logic [31:0] priority_shadow_reg;
    logic [`IVS_IRQ_W-1:0] serviced_irq_number;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] wmask;
    logic [31:0] rd_next;
    logic wr_go;
    logic off_hit;
    logic [2:0] off_idx;
    logic [`IVS_SEL_W-1:0] priority_shadow_select;
    logic [2:0] set_next;
    logic use_next;
    logic [31:0] addr_next;
    logic [OFW-1:0] src_off;

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;

    // Byte-enable mask and offset-table decode
    always_comb begin
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        off_idx = avs_address[4:2];
        off_hit = (avs_address >= `IVS_OFF_BASE) &&
                  (avs_address < `IVS_OFF_BASE + 8'(4 * NSRC)) &&
                  (avs_address[1:0] == 2'b00);
        wr_go = avs_write && !wait_reg;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        if (avs_address == `IVS_PRIORITY_SHADOW_ASSIGN_ADDR) begin
            rd_next = priority_shadow_reg;
        end else if (avs_address == `IVS_STAT_ADDR) begin
            rd_next[`IVS_IRQ_W-1:0] = serviced_irq_number;
        end else if (off_hit) begin
            rd_next[`IVS_OFF_MSB:`IVS_OFF_LSB] = vector_offset_field[off_idx];
        end
    end

    // Bus handshake: one wait cycle, then waitrequest low for one cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            if ((avs_read || avs_write) && wait_reg) begin
                wait_reg <= 1'b0;
                rdata_reg <= avs_read ? rd_next : 32'h0000_0000;
            end else begin
                wait_reg <= 1'b1;
            end
        end
    end

    // Per-source offset table, written under byte enables
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < NSRC; i++) begin
                vector_offset_field[i] <= `IVS_OFF_RST;
            end
        end else if (ce && wr_go && off_hit) begin
            vector_offset_field[off_idx] <= (vector_offset_field[off_idx] &
                ~wmask[`IVS_OFF_MSB:`IVS_OFF_LSB]) |
                (avs_writedata[`IVS_OFF_MSB:`IVS_OFF_LSB] &
                wmask[`IVS_OFF_MSB:`IVS_OFF_LSB]);
        end
    end

    // Shadow assignment register; bits 3:1 stay zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            priority_shadow_reg <= `IVS_PRIORITY_SHADOW_ASSIGN_RST;
        end else if (ce && wr_go && avs_address == `IVS_PRIORITY_SHADOW_ASSIGN_ADDR) begin
            priority_shadow_reg <= (priority_shadow_reg & ~(wmask & `IVS_PRIORITY_SHADOW_ASSIGN_MASK)) |
                (avs_writedata & wmask & `IVS_PRIORITY_SHADOW_ASSIGN_MASK);
        end
    end

    // Shadow set and vector address for the accepted interrupt
    always_comb begin
        priority_shadow_select = priority_shadow_reg[{accept_in.prio, 2'b00} +: `IVS_SEL_W];
        if (accept_in.prio == 3'd0 || priority_shadow_select[`IVS_SEL_W-1]) begin
            set_next = 3'd0;
        end else begin
            set_next = priority_shadow_select[2:0];
        end
        if (accept_in.single_vector) begin
            use_next = priority_shadow_reg[`IVS_SS0_BIT];
        end else begin
            use_next = 1'b1;
        end
        if (accept_in.irq_num < 8'(NSRC)) begin
            src_off = vector_offset_field[accept_in.irq_num[2:0]];
        end else begin
            src_off = `IVS_OFF_RST;
        end
        addr_next = exception_base + {14'h0000, src_off, 1'b0};
    end

    // Vector answer, a one-cycle pulse per acceptance
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            vector_out_reg <= '0;
        end else if (ce) begin
            vector_out_reg.valid <= accept_in.valid;
            if (accept_in.valid) begin
                vector_out_reg.addr <= addr_next;
                vector_out_reg.shadow_set <= set_next;
                vector_out_reg.shadow_use <= use_next;
            end
        end
    end

    // Last serviced interrupt number
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            serviced_irq_number <= 8'h00;
        end else if (ce && accept_in.valid) begin
            serviced_irq_number <= accept_in.irq_num;
        end
    end

    // Checks, all on the system clock and off while reset is low
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Accept taken at this edge
    logic acc;
    // Read taken at this edge at an address with nothing behind it
    logic rd_unmapped;
    assign acc = ce && accept_in.valid;
    assign rd_unmapped = ce && avs_read && avs_waitrequest && !off_hit &&
        (avs_address != `IVS_PRIORITY_SHADOW_ASSIGN_ADDR) && (avs_address != `IVS_STAT_ADDR);

    // Request taken while waitrequest is high
    sequence s_req;
        ce && (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // Answer cycle with the clock enable still high
    sequence s_ans;
        ce && !avs_waitrequest;
    endsequence

    // Bus: answer one cycle after the request is taken
    AST_BUS_ANSWER: assert property (s_req |=> !avs_waitrequest)
        else $error("waitrequest did not drop after a taken request");
    // Bus: answer stands one cycle only
    AST_BUS_RELEASE: assert property (s_req ##1 s_ans |=> avs_waitrequest)
        else $error("waitrequest stayed low past the answer cycle");
    // Bus: no request keeps the slave waiting
    AST_BUS_IDLE: assert property (ce && !(avs_read || avs_write) && avs_waitrequest
        |=> avs_waitrequest)
        else $error("waitrequest dropped with no request");

    // Offset table: full-word write lands in the field from bits 17:1
    AST_OFF_STORE: assert property (ce && wr_go && off_hit &&
        avs_byteenable == 4'hF |=> vector_offset_field[$past(off_idx)] ==
        $past(avs_writedata[`IVS_OFF_MSB:`IVS_OFF_LSB]))
        else $error("offset field not stored from bits 17:1");
    // Offset table: a read returns the field in bits 17:1
    AST_OFF_READ: assert property (ce && avs_read && avs_waitrequest && off_hit
        |=> avs_readdata == {14'h0, $past(vector_offset_field[off_idx]), 1'b0})
        else $error("offset read not placed in bits 17:1");
    // Unmapped addresses read zero
    AST_RD_UNMAPPED: assert property (rd_unmapped |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    // Shadow register: bits 3:1 never take write data
    AST_SHADOW_GAP: assert property (ce && wr_go &&
        avs_address == `IVS_PRIORITY_SHADOW_ASSIGN_ADDR |=> priority_shadow_reg[3:1] == 3'h0)
        else $error("unused shadow register bits took write data");

    // Vector address: base plus the source offset as a byte distance
    AST_VEC_ADDR: assert property (acc && accept_in.irq_num < 8'(NSRC)
        |=> vector_out_reg.valid && vector_out_reg.addr == $past(exception_base) +
        {14'h0, $past(vector_offset_field[accept_in.irq_num[2:0]]), 1'b0})
        else $error("vector address wrong");
    // Vector address: sources beyond the table land on the base
    AST_VEC_BASE: assert property (acc && accept_in.irq_num >= 8'(NSRC)
        |=> vector_out_reg.valid && vector_out_reg.addr == $past(exception_base))
        else $error("vector address of an untabled source is not the base");
    // Shadow set: a valid select picks its set
    AST_SET_PICK: assert property (acc && accept_in.prio != 3'h0 &&
        !priority_shadow_reg[{accept_in.prio, 2'b11}] |=> vector_out_reg.shadow_set ==
        $past(priority_shadow_reg[{accept_in.prio, 2'b00} +: 3]))
        else $error("shadow set not taken from select field");
    // Shadow set: a reserved select falls back to set 0
    AST_SET_RSVD: assert property (acc &&
        priority_shadow_reg[{accept_in.prio, 2'b11}] |=> vector_out_reg.shadow_set == 3'h0)
        else $error("reserved select did not fall back to set 0");
    // Single-vector interrupts follow the enable bit
    AST_SS0: assert property (acc && accept_in.single_vector
        |=> vector_out_reg.shadow_use == $past(priority_shadow_reg[`IVS_SS0_BIT]))
        else $error("single-vector shadow use wrong");
    // Multi-vector interrupts always use their set
    AST_MULTI_USE: assert property (acc && !accept_in.single_vector
        |=> vector_out_reg.shadow_use)
        else $error("multi-vector interrupt not given a shadow set");
    // Status holds the last serviced number
    AST_STATUS: assert property (acc
        |=> serviced_irq_number == $past(accept_in.irq_num))
        else $error("status does not hold last serviced number");
    // Vector valid only after an acceptance
    AST_VALID_PULSE: assert property (ce && !accept_in.valid
        |=> !vector_out_reg.valid)
        else $error("vector valid without acceptance");
    // Clock enable low freezes answers, status and shadow register
    AST_CE_HOLD: assert property (!ce |=> $stable(vector_out_reg) &&
        $stable(serviced_irq_number) && $stable(priority_shadow_reg) &&
        $stable(avs_waitrequest))
        else $error("state moved while the clock enable was low");
endmodule

// [pkg/ivs_params.svh]
// Constants for the interrupt vector, shadow select and status block
// Behaviour
// - Interrupt sources 0 to 7 each have their own software-written vector offset that sets their entry; higher numbers use the base.
// - The offset field sits in bits 17 to 1 and is a distance from the exception base.
// - Priority levels 1 to 7 each have a software-written field choosing one of the shadow sets; priority 0 always uses set 0.
// - A four-bit select value of 0 to 7 picks shadow set 0 to 7 for that priority.
// - A select value with its top bit set is reserved and falls back to shadow set 0.
// - Bit 0 of the shadow register decides if single-vector interrupts use a shadow set.
// - The status register shows in bits 7 to 0 the last serviced interrupt number.
`ifndef IVS_PARAMS_SVH
`define IVS_PARAMS_SVH
`define IVS_NUM_SRC 8
`define IVS_ADDR_W 8
`define IVS_PRIORITY_SHADOW_ASSIGN_ADDR 8'h00
`define IVS_STAT_ADDR 8'h04
`define IVS_OFF_BASE 8'h40
`define IVS_OFF_LSB 1
`define IVS_OFF_MSB 17
`define IVS_SS0_BIT 0
`define IVS_SEL_W 4
`define IVS_PRIORITY_SHADOW_ASSIGN_MASK 32'hFFFF_FFF1
`define IVS_PRIORITY_SHADOW_ASSIGN_RST 32'h0000_0000
`define IVS_OFF_RST 17'h0_0000
`define IVS_IRQ_W 8
`endif

// [pkg/ivs_pkg.sv]
// Types shared by the interrupt vector and shadow select block
package ivs_pkg;
    // One interrupt accepted by the core
    typedef struct packed {
        logic valid;
        logic [7:0] irq_num;
        logic [2:0] prio;
        logic single_vector;
    } ivs_accept_t;
    // Vector answer presented to the core
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [2:0] shadow_set;
        logic shadow_use;
    } ivs_vector_t;
endpackage

// [verification/ivs_core_model.sv]
// Core-side model that raises interrupt accepts toward the block
`timescale 1ns/1ps
module ivs_core_model
    import ivs_pkg::*;
#(parameter logic [31:0] BASE = 32'h1234_0000) (
    input wire logic clk_sys,
    output ivs_accept_t accept_in,
    output logic [31:0] exception_base
);
    // Base value is arbitrary
    assign exception_base = BASE;
    initial accept_in = '0;
    // One-cycle accept pulse; released fields are scrambled, not left stale
    task automatic take(input logic [7:0] irq, input logic [2:0] prio, input logic sv);
        @(posedge clk_sys);
        accept_in <= {1'b1, irq, prio, sv};
        @(posedge clk_sys);
        accept_in <= {1'b0, ~irq, ~prio, ~sv};
    endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for the vector offset, shadow select and status block
`timescale 1ns/1ps
`include "ivs_params.svh"
module testbench;
    import ivs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic avs_waitrequest;
    logic ce = 1'b1;
    logic [3:0] be = 4'hF;
    logic [7:0] avs_address = 8'h00;
    logic [7:0] irq;
    logic [3:0] s;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, exception_base, q, sel;
    logic [31:0] offs [8] = '{default: 32'h0};
    ivs_accept_t accept_in;
    ivs_vector_t vector_out_reg;
    int n_mismatch = 0;
    int checked = 0;
    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;
    ivs_top ivs_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .exception_base(exception_base), .accept_in(accept_in), .vector_out_reg(vector_out_reg));
    ivs_core_model ivs_core_model_i (.clk_sys(clk_sys), .accept_in(accept_in),
        .exception_base(exception_base));
    // Compare and count
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog: the tests need fewer than two hundred cycles, so 3000 means a hang
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(1'b0, `IVS_PRIORITY_SHADOW_ASSIGN_ADDR, 32'h0);
        check("shadow reset", q, `IVS_PRIORITY_SHADOW_ASSIGN_RST);
        bus(1'b0, `IVS_OFF_BASE + 8'h0C, 32'h0);
        check("offset reset", q, 32'h0);
        bus(1'b1, `IVS_OFF_BASE + 8'h0C, 32'hFFFF_FFFF);
        bus(1'b0, `IVS_OFF_BASE + 8'h0C, 32'h0);
        check("offset field", q, 32'h0003_FFFE);
        offs[3] = 32'h0003_FFFE;
        // Only lane 0 enabled: field bits 7:1 change, the rest stay zero
        be <= 4'h1;
        bus(1'b1, `IVS_OFF_BASE + 8'h14, 32'hFFFF_FFFF);
        be <= 4'hF;
        bus(1'b0, `IVS_OFF_BASE + 8'h14, 32'h0);
        check("offset lanes", q, 32'h0000_00FE);
        offs[5] = 32'h0000_00FE;
        bus(1'b1, 8'h80, 32'hFFFF_FFFF);
        bus(1'b0, 8'h80, 32'h0);
        check("unmapped", q, 32'h0);
        bus(1'b1, `IVS_STAT_ADDR, 32'h0000_00FF);
        bus(1'b0, `IVS_STAT_ADDR, 32'h0);
        check("status write", q, 32'h0);
        $display("test registers done");
        // Every priority, reserved selects, both single-vector settings
        for (int b = 0; b < 2; b++) begin
            sel = 32'h76F4_821E | 32'(b);
            bus(1'b1, `IVS_PRIORITY_SHADOW_ASSIGN_ADDR, sel);
            bus(1'b0, `IVS_PRIORITY_SHADOW_ASSIGN_ADDR, 32'h0);
            check("shadow field", q, sel & `IVS_PRIORITY_SHADOW_ASSIGN_MASK);
            for (int p = 0; p < 8; p++) begin
                irq = (p == 7) ? 8'hC8 : 8'(p);
                s = sel[4 * p +: 4];
                ivs_core_model_i.take(irq, 3'(p), p[0]);
                #1;
                check("vector valid", 32'(vector_out_reg.valid), 32'h1);
                check("vector addr", vector_out_reg.addr,
                    exception_base + ((irq < 8) ? offs[irq[2:0]] : 32'h0));
                check("shadow set", 32'(vector_out_reg.shadow_set),
                    (p == 0 || s[3]) ? 32'h0 : 32'(s[2:0]));
                check("shadow use", 32'(vector_out_reg.shadow_use),
                    p[0] ? 32'(b) : 32'h1);
                bus(1'b0, `IVS_STAT_ADDR, 32'h0);
                check("status", q, 32'(irq));
            end
        end
        $display("test accepts done");
        // Clock enable low: an accept is ignored and status keeps the last one
        ce <= 1'b0;
        ivs_core_model_i.take(8'h2A, 3'h1, 1'b0);
        #1;
        check("frozen valid", 32'(vector_out_reg.valid), 32'h0);
        @(posedge clk_sys);
        ce <= 1'b1;
        bus(1'b0, `IVS_STAT_ADDR, 32'h0);
        check("frozen status", q, 32'h0000_00C8);
        $display("test clock enable done");
        // Reset in mid-run clears table, shadow register, status and answer
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(1'b0, `IVS_STAT_ADDR, 32'h0);
        check("status after reset", q, 32'h0);
        bus(1'b0, `IVS_OFF_BASE + 8'h0C, 32'h0);
        check("offset after reset", q, 32'h0);
        bus(1'b0, `IVS_PRIORITY_SHADOW_ASSIGN_ADDR, 32'h0);
        check("shadow after reset", q, `IVS_PRIORITY_SHADOW_ASSIGN_RST);
        check("vector after reset", vector_out_reg.addr, 32'h0);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
